/* common/imc_pkg.sv */
package imc_pkg;

	// engine sequencing states
	typedef enum logic [3:0] {
		IMC_IDLE,
		IMC_START_A,
		IMC_START_B,
		IMC_RS_A,
		IMC_RS_B,
		IMC_RS_C,
		IMC_XFER_LO,
		IMC_XFER_HI,
		IMC_ACK_LO,
		IMC_ACK_HI,
		IMC_STOP_A,
		IMC_STOP_B,
		IMC_STOP_C
	} imc_state_t;

	// bit counts within a byte
	localparam logic [3:0] IMC_BIT_FIRST = 4'h0;
	localparam logic [3:0] IMC_RX_LAST = 4'h7;
	localparam logic [3:0] IMC_TX_LAST = 4'h8;

	// reset values
	localparam logic [7:0] IMC_BUF_RST = 8'h00;
	localparam logic [8:0] IMC_BRG_RST = 9'h000;
	localparam logic IMC_PIN_RST = 1'b1;
	localparam logic IMC_FLAG_RST = 1'b0;

endpackage : imc_pkg

/* hw/imc_baud_gen.sv */
`timescale 1ns/1ns
// half-period timer: one tick every 2*(reload+1) clocks
module imc_baud_gen (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [7:0] reload,
	// timeout
	output logic tick
);

	logic [8:0] cnt;
	logic [8:0] reload_cnt;

	assign reload_cnt = {reload, 1'b1};
	assign tick = !load && (cnt == imc_pkg::IMC_BRG_RST);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= imc_pkg::IMC_BRG_RST;
		end else if (load || tick) begin
			cnt <= reload_cnt; // RULE23
		end else begin
			cnt <= cnt - 9'h001;
		end
	end

endmodule : imc_baud_gen

/* hw/imc_master.sv */
`timescale 1ns/1ns
// Functional notes
// [RULE1] byte done while buffer full sets overflow
// [RULE2] buffer write during receive sets write collision
// [RULE3] read address shifted out, ack captured, flag
// [RULE4] receive byte then set flag and buffer-full
// [RULE5] software picks ack value, ends with nack/stop
// [RULE6] ack request drives SCL low, ack on SDA
// [RULE7] clear ack value for ack, set for nack
// [RULE8] ack: low one period, high one period
// [RULE9] buffer write during ack sets write collision
// [RULE10] stop: SDA low, release SCL, then SDA
// [RULE11] stop seen, one period later flag set
// [RULE12] buffer write during stop sets write collision
// [RULE13] interrupt flag wakes sleeping processor when enabled
// [RULE14] reset disables port, abandons transfer
// [RULE15] start/stop seen cleared on reset, disable
// [RULE16] bus free rules; interrupt on stop when busy
// [RULE17] released one read zero: collision, go idle
// [RULE18] transmit collision clears buffer full, frees lines
// [RULE19] sequence collision aborts and clears its request
// [RULE20] after collision, stop on bus sets flag
// [RULE21] new write after collision starts at bit one
// [RULE22] start aborted when lines low early
// [RULE23] baud timer reloads from reload value
// [RULE24] reload values 0x00 to 0x02 not used
// [RULE25] receive request ignored unless port idle
// [RULE26] buffer read clears buffer full
// [RULE27] collision flags stay until software clears
module imc_master (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// configuration
	input wire logic port_enable,
	input wire logic interrupt_enable,
	input wire logic [7:0] baud_reload_value,
	input wire logic acknowledge_value,
	// request set pulses
	input wire logic set_start,
	input wire logic set_restart,
	input wire logic set_stop,
	input wire logic set_receive,
	input wire logic set_acknowledge,
	// transfer buffer access
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	input wire logic buf_rd,
	// flag clear pulses
	input wire logic clr_interrupt,
	input wire logic clr_overflow,
	input wire logic clr_write_collision,
	input wire logic clr_bus_collision,
	// request bits
	output logic start_request,
	output logic restart_request,
	output logic stop_request,
	output logic receive_go,
	output logic acknowledge_sequence_go,
	// status
	output logic [7:0] transfer_buffer,
	output logic buffer_full_flag,
	output logic receive_overflow_flag,
	output logic write_collision_flag,
	output logic bus_collision_flag,
	output logic port_interrupt_flag,
	output logic acknowledge_result,
	output logic start_seen,
	output logic stop_seen,
	output logic wake,
	// bus pins, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	function automatic logic flag_upd(input logic cur, input logic set,
		input logic clr);
		flag_upd = set | (cur & !clr);
	endfunction : flag_upd

	logic rst_meta;
	logic rst_n;
	imc_pkg::imc_state_t state;
	imc_pkg::imc_state_t next_state;
	logic enter;
	logic brg_load;
	logic brg_tick;
	logic hold_wait;
	logic [7:0] shift_register;
	logic [3:0] bit_cnt;
	logic rx_mode;
	logic scl_hold;
	logic sda_hold;
	logic coll_watch;
	logic sda_q;
	logic scl_q;

	// reset release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// decode
	wire is_idle = state == imc_pkg::IMC_IDLE;
	wire any_req = start_request | restart_request | stop_request
		| receive_go | acknowledge_sequence_go;
	wire idle_quiet = is_idle & !any_req & port_enable;
	wire wr_ok = buf_wr & idle_quiet;
	wire in_xfer = state == imc_pkg::IMC_XFER_LO
		|| state == imc_pkg::IMC_XFER_HI;
	wire in_ack = state == imc_pkg::IMC_ACK_LO
		|| state == imc_pkg::IMC_ACK_HI;
	wire hi_tick = state == imc_pkg::IMC_XFER_HI && brg_tick;
	wire tx_data = !rx_mode && bit_cnt < imc_pkg::IMC_TX_LAST;
	wire tx_bit8 = hi_tick && !rx_mode && bit_cnt == imc_pkg::IMC_RX_LAST;
	wire done_tx = hi_tick && !rx_mode && bit_cnt == imc_pkg::IMC_TX_LAST;
	wire done_rx = hi_tick && rx_mode && bit_cnt == imc_pkg::IMC_RX_LAST;
	wire start_done = state == imc_pkg::IMC_START_B && brg_tick;
	wire rs_done = state == imc_pkg::IMC_RS_C && brg_tick;
	wire ack_done = state == imc_pkg::IMC_ACK_HI && brg_tick;
	wire stop_done = state == imc_pkg::IMC_STOP_C && brg_tick;
	wire abort = !port_enable; // RULE14
	wire bus_start = sda_q & !sda_in & scl_q & scl_in;
	wire bus_stop = !sda_q & sda_in & scl_q & scl_in;
	wire ext_stop = bus_stop & is_idle & (coll_watch | start_seen); // RULE16 RULE20

	// arbitration: released line read low; SDA while SCL high, except start (either line low) and stop (SCL low)
	wire coll_start = state == imc_pkg::IMC_START_A
		&& (!sda_in || !scl_in); // RULE22
	wire coll_data = state == imc_pkg::IMC_XFER_HI && tx_data
		&& shift_register[7] && scl_in && !sda_in; // RULE17
	wire coll_ack = state == imc_pkg::IMC_ACK_HI && acknowledge_value
		&& scl_in && !sda_in; // RULE17
	wire coll_rs = state == imc_pkg::IMC_RS_B && scl_in && !sda_in;
	wire coll_stop = state == imc_pkg::IMC_STOP_C && !scl_in;
	wire coll = port_enable
		& (coll_start | coll_data | coll_ack | coll_rs | coll_stop);
	wire seq_end = coll | abort;

	// timer holds while waiting on the bus
	always_comb begin
		case (state)
			imc_pkg::IMC_STOP_A: hold_wait = sda_in;
			imc_pkg::IMC_XFER_HI: hold_wait = !scl_in;
			imc_pkg::IMC_ACK_HI: hold_wait = !scl_in;
			imc_pkg::IMC_RS_B: hold_wait = !scl_in;
			imc_pkg::IMC_STOP_B: hold_wait = !scl_in;
			imc_pkg::IMC_STOP_C: hold_wait = !(sda_in && scl_in);
			default: hold_wait = 1'b0;
		endcase
	end

	assign brg_load = is_idle | enter | hold_wait;

	imc_baud_gen u_baud (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(brg_load),
		.reload(baud_reload_value),
		.tick(brg_tick)
	);

	// sequencer
	always_comb begin
		next_state = state;
		if (seq_end) begin
			next_state = imc_pkg::IMC_IDLE; // RULE17 RULE19
		end else begin
			case (state)
				imc_pkg::IMC_IDLE: begin
					if (start_request) begin
						next_state = imc_pkg::IMC_START_A;
					end else if (restart_request) begin
						next_state = imc_pkg::IMC_RS_A;
					end else if (stop_request) begin
						next_state = imc_pkg::IMC_STOP_A; // RULE10
					end else if (acknowledge_sequence_go) begin
						next_state = imc_pkg::IMC_ACK_LO; // RULE6
					end else if (receive_go || wr_ok) begin
						next_state = imc_pkg::IMC_XFER_LO; // RULE3 RULE4
					end
				end
				imc_pkg::IMC_START_A: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_START_B;
					end
				end
				imc_pkg::IMC_RS_A: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_RS_B;
					end
				end
				imc_pkg::IMC_RS_B: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_RS_C;
					end
				end
				imc_pkg::IMC_XFER_LO: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_XFER_HI;
					end
				end
				imc_pkg::IMC_XFER_HI: begin
					if (done_tx || done_rx) begin
						next_state = imc_pkg::IMC_IDLE;
					end else if (brg_tick) begin
						next_state = imc_pkg::IMC_XFER_LO;
					end
				end
				imc_pkg::IMC_ACK_LO: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_ACK_HI; // RULE8
					end
				end
				imc_pkg::IMC_STOP_A: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_STOP_B; // RULE10
					end
				end
				imc_pkg::IMC_STOP_B: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_STOP_C; // RULE10
					end
				end
				default: begin
					if (brg_tick) begin
						next_state = imc_pkg::IMC_IDLE; // RULE8 RULE11
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= imc_pkg::IMC_IDLE;
			enter <= 1'b0;
		end else begin
			state <= next_state;
			enter <= next_state != state;
		end
	end

	// request bits, accepted only in a quiet idle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_request <= imc_pkg::IMC_FLAG_RST;
			restart_request <= imc_pkg::IMC_FLAG_RST;
			stop_request <= imc_pkg::IMC_FLAG_RST;
			receive_go <= imc_pkg::IMC_FLAG_RST;
			acknowledge_sequence_go <= imc_pkg::IMC_FLAG_RST;
		end else begin
			start_request <= (start_request | (set_start & idle_quiet))
				& !(start_done | seq_end);
			restart_request <= (restart_request | (set_restart & idle_quiet))
				& !(rs_done | seq_end);
			stop_request <= (stop_request | (set_stop & idle_quiet))
				& !(stop_done | seq_end); // RULE11 RULE19
			receive_go <= (receive_go | (set_receive & idle_quiet))
				& !(done_rx | seq_end); // RULE25
			acknowledge_sequence_go <= (acknowledge_sequence_go
				| (set_acknowledge & idle_quiet))
				& !(ack_done | seq_end); // RULE8 RULE19
		end
	end

	// status flags, a set beats a clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			buffer_full_flag <= imc_pkg::IMC_FLAG_RST;
			receive_overflow_flag <= imc_pkg::IMC_FLAG_RST;
			write_collision_flag <= imc_pkg::IMC_FLAG_RST;
			bus_collision_flag <= imc_pkg::IMC_FLAG_RST;
			port_interrupt_flag <= imc_pkg::IMC_FLAG_RST;
		end else begin
			buffer_full_flag <= flag_upd(buffer_full_flag, wr_ok | done_rx,
				buf_rd | tx_bit8 | coll | abort); // RULE4 RULE18 RULE26
			receive_overflow_flag <= flag_upd(receive_overflow_flag,
				done_rx & buffer_full_flag, clr_overflow); // RULE1
			write_collision_flag <= flag_upd(write_collision_flag,
				buf_wr & !wr_ok & port_enable,
				clr_write_collision); // RULE2 RULE9 RULE12 RULE27
			bus_collision_flag <= flag_upd(bus_collision_flag, coll,
				clr_bus_collision); // RULE17 RULE27
			port_interrupt_flag <= flag_upd(port_interrupt_flag,
				start_done | rs_done | done_tx | done_rx | ack_done
				| stop_done | ext_stop,
				clr_interrupt); // RULE3 RULE11 RULE20
		end
	end

	// data path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			transfer_buffer <= imc_pkg::IMC_BUF_RST;
			shift_register <= imc_pkg::IMC_BUF_RST;
			acknowledge_result <= imc_pkg::IMC_FLAG_RST;
		end else begin
			if (wr_ok) begin
				transfer_buffer <= buf_wdata;
				shift_register <= buf_wdata; // RULE21
			end else if (hi_tick) begin
				shift_register <= {shift_register[6:0],
					rx_mode & sda_in};
			end
			if (done_rx) begin
				transfer_buffer <= {shift_register[6:0], sda_in}; // RULE4
			end
			if (done_tx) begin
				acknowledge_result <= sda_in; // RULE3
			end
		end
	end

	// bit position and direction
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= imc_pkg::IMC_BIT_FIRST;
			rx_mode <= imc_pkg::IMC_FLAG_RST;
		end else if (is_idle) begin
			bit_cnt <= imc_pkg::IMC_BIT_FIRST; // RULE21
			rx_mode <= receive_go;
		end else if (hi_tick) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// line holds between sequences
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_hold <= imc_pkg::IMC_FLAG_RST;
			sda_hold <= imc_pkg::IMC_FLAG_RST;
		end else if (seq_end || stop_done) begin
			scl_hold <= 1'b0; // RULE18 RULE19
			sda_hold <= 1'b0;
		end else if (start_done || rs_done) begin
			scl_hold <= 1'b1;
			sda_hold <= 1'b1;
		end else if (done_tx || done_rx || ack_done) begin
			scl_hold <= 1'b1; // RULE8
			sda_hold <= 1'b0;
		end
	end

	// bus monitor
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sda_q <= imc_pkg::IMC_PIN_RST;
			scl_q <= imc_pkg::IMC_PIN_RST;
			start_seen <= imc_pkg::IMC_FLAG_RST;
			stop_seen <= imc_pkg::IMC_FLAG_RST;
			coll_watch <= imc_pkg::IMC_FLAG_RST;
		end else begin
			sda_q <= sda_in;
			scl_q <= scl_in;
			if (abort) begin
				start_seen <= 1'b0; // RULE15
				stop_seen <= 1'b0;
			end else if (bus_start) begin
				start_seen <= 1'b1;
				stop_seen <= 1'b0;
			end else if (bus_stop) begin
				start_seen <= 1'b0;
				stop_seen <= 1'b1; // RULE11 RULE16
			end
			coll_watch <= coll | (coll_watch & !bus_stop & !abort);
		end
	end

	// open-drain pins
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = port_enable & ((is_idle & scl_hold)
		| state == imc_pkg::IMC_RS_A | state == imc_pkg::IMC_XFER_LO
		| state == imc_pkg::IMC_ACK_LO
		| state == imc_pkg::IMC_STOP_A); // RULE6 RULE8 RULE10
	assign sda_oe = port_enable & ((is_idle & sda_hold)
		| state == imc_pkg::IMC_START_B | state == imc_pkg::IMC_RS_C
		| (in_xfer & tx_data & !shift_register[7])
		| (in_ack & !acknowledge_value) // RULE6
		| state == imc_pkg::IMC_STOP_A
		| state == imc_pkg::IMC_STOP_B); // RULE10
	assign wake = port_interrupt_flag & interrupt_enable; // RULE13

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_overflow_set: assert property (done_rx && buffer_full_flag // RULE1
		|=> receive_overflow_flag)
		else $error("overflow not flagged");
	a_write_refused: assert property (buf_wr && !is_idle && port_enable // RULE2
		|=> write_collision_flag
		&& ($stable(transfer_buffer) || $past(done_rx)))
		else $error("busy write not refused");
	a_receive_end: assert property (done_rx && !seq_end // RULE4
		|=> buffer_full_flag && port_interrupt_flag && !receive_go)
		else $error("receive end flags wrong");
	a_ack_drive: assert property (state == imc_pkg::IMC_ACK_LO // RULE6
		&& port_enable |-> scl_oe && sda_oe == !acknowledge_value)
		else $error("ack pins wrong");
	a_ack_finish: assert property (ack_done && !seq_end // RULE8
		|=> is_idle && !acknowledge_sequence_go && scl_oe)
		else $error("ack end wrong");
	a_stop_finish: assert property (stop_done && !seq_end // RULE11
		|=> !stop_request && port_interrupt_flag && !scl_oe)
		else $error("stop end wrong");
	a_coll_idle: assert property (coll // RULE17
		|=> bus_collision_flag && is_idle && !any_req)
		else $error("collision not handled");
	a_seen_clear: assert property (!port_enable // RULE15
		|=> !start_seen && !stop_seen)
		else $error("seen bits not cleared");
	a_bcol_sticky: assert property (bus_collision_flag // RULE27
		&& !clr_bus_collision |=> bus_collision_flag)
		else $error("collision flag lost");

endmodule : imc_master

/* test/imc_slave_model.sv */
`timescale 1ns/1ns
// far side slave: acks written bytes, returns rx_byte on reads
module imc_slave_model (
	// clock
	input wire logic clk_sys,
	// bus level
	input wire logic scl,
	// behaviour
	input wire logic arm,
	input wire logic read_mode,
	input wire logic [7:0] rx_byte,
	input wire logic [4:0] stretch,
	// pulls, high = line low
	output logic sda_pull,
	output logic scl_pull
);
	logic [3:0] cnt = 4'hf;
	logic scl_q = 1'b1;
	logic [4:0] hold = 5'h00;
	// data only changes while scl is low
	wire logic [3:0] idx = scl ? cnt - 4'h1 : cnt;
	wire logic rd_pull = read_mode && idx <= 4'h7 && !rx_byte[3'h7 - idx[2:0]];
	wire logic ack_pull = !read_mode && (scl ? cnt == 4'h9 : cnt == 4'h8);
	assign sda_pull = rd_pull || ack_pull;
	assign scl_pull = hold != 5'h00;
	always @(posedge scl or posedge arm) begin
		if (arm)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	// clock stretch after each falling edge
	always @(posedge clk_sys) begin
		scl_q <= scl;
		if (scl_q && !scl)
			hold <= stretch;
		else if (hold != 5'h00)
			hold <= hold - 5'h01;
	end
endmodule : imc_slave_model

/* test/i2c_master_ack_stop_arbitration_tb_top.sv */
`timescale 1ns/1ns
module i2c_master_ack_stop_arbitration_tb_top;
	logic clk_sys, resetn, port_enable, interrupt_enable, acknowledge_value;
	logic [7:0] baud_reload_value, buf_wdata, rx_byte, saved;
	logic set_start, set_restart, set_stop, set_receive, set_acknowledge;
	logic buf_wr, buf_rd, clr_interrupt, clr_overflow;
	logic clr_write_collision, clr_bus_collision;
	logic start_request, restart_request, stop_request, receive_go;
	logic acknowledge_sequence_go, buffer_full_flag, receive_overflow_flag;
	logic write_collision_flag, bus_collision_flag, port_interrupt_flag;
	logic acknowledge_result, start_seen, stop_seen, wake;
	logic [7:0] transfer_buffer;
	logic scl_oe, sda_oe, sda_pull, scl_pull, tb_sda, tb_scl, arm, read_mode;
	logic [4:0] stretch;
	int mismatches, comparisons, seed;
	wire logic scl_bus = !(scl_oe | scl_pull | tb_scl);
	wire logic sda_bus = !(sda_oe | sda_pull | tb_sda);

	imc_master imc_master_i (.clk_sys, .resetn, .port_enable,
		.interrupt_enable, .baud_reload_value, .acknowledge_value,
		.set_start, .set_restart, .set_stop, .set_receive, .set_acknowledge,
		.buf_wr, .buf_wdata, .buf_rd, .clr_interrupt, .clr_overflow,
		.clr_write_collision, .clr_bus_collision, .start_request,
		.restart_request, .stop_request, .receive_go, .acknowledge_sequence_go,
		.transfer_buffer, .buffer_full_flag, .receive_overflow_flag,
		.write_collision_flag, .bus_collision_flag, .port_interrupt_flag,
		.acknowledge_result, .start_seen, .stop_seen, .wake,
		.scl_in(scl_bus), .scl_out(), .scl_oe, .sda_in(sda_bus), .sda_out(),
		.sda_oe);
	imc_slave_model imc_slave_model_i (.clk_sys, .scl(scl_bus), .arm,
		.read_mode, .rx_byte, .stretch, .sda_pull, .scl_pull);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (40000) @(posedge clk_sys);
		mismatches++;
		$display("wrong value watchdog expected done seen hang");
		final_report();
	end

	task automatic check_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task automatic check_byte(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse

	function automatic logic cond(input int k);
		case (k)
			0: return start_request === 1'b0;
			1: return port_interrupt_flag === 1'b1;
			2: return stop_request === 1'b0;
			3: return acknowledge_sequence_go === 1'b0;
			5: return restart_request === 1'b0;
			default: return bus_collision_flag === 1'b1;
		endcase
	endfunction : cond

	task automatic wait_for(input int k);
		int n;
		n = 0;
		while (!cond(k) && n < 4000) begin
			cyc(1);
			n++;
		end
		check_bit("wait done", 1'b1, cond(k));
	endtask : wait_for

	task automatic write_byte(input logic [7:0] d);
		buf_wdata = d;
		arm = 1'b1;
		buf_wr = 1'b1;
		cyc(1);
		arm = 1'b0;
		buf_wr = 1'b0;
	endtask : write_byte

	task automatic receive(input logic ovf);
		rx_byte = 8'($random(seed));
		read_mode = 1'b1;
		saved = transfer_buffer;
		pulse(arm);
		pulse(clr_interrupt);
		pulse(set_receive);
		cyc(2);
		buf_wdata = ~saved;
		pulse(buf_wr);
		check_bit("rx write_collision_flag", 1'b1, write_collision_flag);
		check_byte("rx kept", saved, transfer_buffer);
		pulse(clr_write_collision);
		wait_for(1);
		check_byte("rx data", rx_byte, transfer_buffer);
		check_bit("rx full", 1'b1, buffer_full_flag);
		check_bit("rx done", 1'b0, receive_go);
		check_byte("rx clocks", 8'h08, {4'h0, imc_slave_model_i.cnt});
		check_bit("rx ovf", ovf, receive_overflow_flag);
	endtask : receive

	task automatic do_ack(input logic v);
		acknowledge_value = v;
		pulse(clr_interrupt);
		pulse(set_acknowledge);
		cyc(2);
		check_bit("ack scl", 1'b1, scl_oe);
		check_bit("ack sda", !v, sda_oe);
		pulse(buf_wr);
		check_bit("ack write_collision_flag", 1'b1, write_collision_flag);
		pulse(clr_write_collision);
		wait_for(3);
		check_bit("ack intr", 1'b1, port_interrupt_flag);
	endtask : do_ack

	initial begin
		seed = 68;
		{resetn, interrupt_enable, acknowledge_value, set_start, set_restart} = '0;
		{set_stop, set_receive, set_acknowledge, buf_wr, buf_rd} = '0;
		{clr_interrupt, clr_overflow, clr_write_collision} = '0;
		{clr_bus_collision, tb_sda, tb_scl, arm, read_mode} = '0;
		port_enable = 1'b1;
		buf_wdata = 8'h00;
		rx_byte = 8'h00;
		baud_reload_value = 8'h03 + 8'($random(seed) & 3);
		stretch = 5'($random(seed));
		cyc(5);
		resetn = 1'b1;
		cyc(4);
		check_bit("rst lines", 1'b0, scl_oe | sda_oe);
		check_bit("rst seen", 1'b0, start_seen | stop_seen);
		check_byte("rst buffer", 8'h00, transfer_buffer);
		$display("test reset done");
		pulse(set_start);
		wait_for(0);
		pulse(clr_interrupt);
		write_byte({7'($random(seed)), 1'b1});
		wait_for(1);
		check_bit("addr ack", 1'b0, acknowledge_result);
		receive(1'b0);
		do_ack(1'b0);
		receive(1'b1);
		pulse(buf_rd);
		check_bit("read clears", 1'b0, buffer_full_flag);
		pulse(clr_overflow);
		do_ack(1'b1);
		pulse(clr_interrupt);
		pulse(set_stop);
		cyc(1);
		check_bit("stop sda", 1'b1, sda_oe);
		pulse(set_receive);
		check_bit("rx ignored", 1'b0, receive_go);
		pulse(buf_wr);
		check_bit("stop write_collision_flag", 1'b1, write_collision_flag);
		pulse(clr_write_collision);
		wait_for(2);
		check_bit("stop seen", 1'b1, stop_seen);
		check_bit("stop intr", 1'b1, port_interrupt_flag);
		check_bit("stop free", 1'b0, scl_oe | sda_oe);
		port_enable = 1'b0;
		cyc(2);
		check_bit("off seen", 1'b0, stop_seen | start_seen);
		port_enable = 1'b1;
		cyc(3);
		$display("test read done");
		pulse(set_start);
		wait_for(0);
		read_mode = 1'b0;
		write_byte(8'h80 | 8'($random(seed)));
		tb_sda = 1'b1;
		wait_for(4);
		check_bit("bcol full", 1'b0, buffer_full_flag);
		check_bit("bcol free", 1'b0, scl_oe | sda_oe);
		pulse(clr_interrupt);
		cyc(40);
		tb_sda = 1'b0;
		cyc(5);
		check_bit("bus stop", 1'b1, port_interrupt_flag);
		check_bit("bcol kept", 1'b1, bus_collision_flag);
		pulse(clr_bus_collision);
		check_bit("bcol clr", 1'b0, bus_collision_flag);
		tb_scl = 1'b1;
		pulse(set_start);
		cyc(4);
		check_bit("start bcol", 1'b1, bus_collision_flag);
		check_bit("start abort", 1'b0, start_request);
		tb_scl = 1'b0;
		pulse(clr_bus_collision);
		pulse(clr_interrupt);
		cyc(3);
		write_byte({1'b0, 7'($random(seed))});
		check_bit("first bit", 1'b1, sda_oe);
		wait_for(1);
		check_bit("resume ack", 1'b0, acknowledge_result);
		pulse(clr_interrupt);
		read_mode = 1'b1;
		rx_byte = 8'hff;
		write_byte(8'($random(seed)));
		wait_for(1);
		check_bit("nack seen", 1'b1, acknowledge_result);
		pulse(clr_interrupt);
		pulse(set_restart);
		wait_for(5);
		check_bit("rs intr", 1'b1, port_interrupt_flag);
		check_bit("rs seen", 1'b1, start_seen);
		for (int i = 0; i < 2; i++) begin
			interrupt_enable = i[0];
			cyc(1);
			check_bit("wake", i[0], wake);
		end
		$display("test collision done");
		final_report();
	end
endmodule : i2c_master_ack_stop_arbitration_tb_top
